// *** rtl/mfp_pkg.sv ***
// package: shared constants and types for the mmu fault priority and domain check
package mfp_pkg;

    // ****************************************************************
    // fault status codes
    // ****************************************************************
    localparam logic [3:0] MFP_FS_ALIGN_A    = 4'h1;
    localparam logic [3:0] MFP_FS_ALIGN_B    = 4'h3;
    localparam logic [3:0] MFP_FS_XWALK_L1   = 4'hC;
    localparam logic [3:0] MFP_FS_XWALK_L2   = 4'hE;
    localparam logic [3:0] MFP_FS_XLAT_SECT  = 4'h5;
    localparam logic [3:0] MFP_FS_XLAT_PAGE  = 4'h7;
    localparam logic [3:0] MFP_FS_DOM_SECT   = 4'h9;
    localparam logic [3:0] MFP_FS_DOM_PAGE   = 4'hB;
    localparam logic [3:0] MFP_FS_PERM_SECT  = 4'hD;
    localparam logic [3:0] MFP_FS_PERM_PAGE  = 4'hF;
    localparam logic [3:0] MFP_FS_XABT_SECT  = 4'h8;
    localparam logic [3:0] MFP_FS_XABT_PAGE  = 4'hA;

    // ****************************************************************
    // domain field and permission encodings
    // ****************************************************************
    localparam logic [1:0] MFP_DOM_NOACC     = 2'h0;
    localparam logic [1:0] MFP_DOM_CLIENT    = 2'h1;
    localparam logic [1:0] MFP_DOM_RSVD      = 2'h2;
    localparam logic [1:0] MFP_DOM_MANAGER   = 2'h3;
    localparam logic [1:0] MFP_AP_SR         = 2'h0;
    localparam logic [1:0] MFP_AP_PRIV_RW    = 2'h1;
    localparam logic [1:0] MFP_AP_USER_RO    = 2'h2;
    localparam logic [1:0] MFP_AP_ALL_RW     = 2'h3;

    // ****************************************************************
    // reset values and geometry
    // ****************************************************************
    localparam logic [31:0] MFP_DAC_RST      = 32'h0000_0000;
    localparam logic [7:0]  MFP_FSR_RST      = 8'h00;
    localparam logic [31:0] MFP_FAR_RST      = 32'h0000_0000;
    localparam int          MFP_NUM_DOMAINS  = 16;
    localparam int          MFP_BOUNDARY_LSB = 10;   // 1KB boundary

    // winning fault class, highest priority first
    typedef enum logic [2:0] {
        MFP_CLS_NONE,
        MFP_CLS_ALIGN,
        MFP_CLS_XWALK,
        MFP_CLS_XLAT,
        MFP_CLS_DOM,
        MFP_CLS_PERM,
        MFP_CLS_XABT
    } mfp_class_t;

endpackage : mfp_pkg

// *** rtl/mfp_check_if.sv ***
// interface: access check request and result between the top and the checker
`timescale 1ns/1ps
interface mfp_check_if;
    import mfp_pkg::*;

    logic [31:0] dac;        // domain access control word
    logic [3:0]  domain;     // domain number from descriptor
    logic [1:0]  ap;         // selected access permission bits
    logic        sys_bit;    // control bit 8
    logic        rom_bit;    // control bit 9
    logic        priv;       // privileged access
    logic        write;      // write access
    logic        dom_fault;  // domain check failed
    logic        perm_fault; // permission check failed

    modport top (output dac, domain, ap, sys_bit, rom_bit, priv, write,
                 input dom_fault, perm_fault);
    modport chk (input dac, domain, ap, sys_bit, rom_bit, priv, write,
                 output dom_fault, perm_fault);
endinterface : mfp_check_if

// *** rtl/mfp_dom_check.sv ***
// module: combinational domain and access permission check
`timescale 1ns/1ps
module mfp_dom_check
    import mfp_pkg::*;
(
    mfp_check_if.chk chk
);
    logic [1:0] dom_field [MFP_NUM_DOMAINS];
    logic [1:0] sel_field;
    logic       allowed;

    // ****************************************************************
    // per-domain field split
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < MFP_NUM_DOMAINS; g++) begin : g_dom
            assign dom_field[g] = chk.dac[2*g+1:2*g];
        end
    endgenerate

    assign sel_field = dom_field[chk.domain];

    // ****************************************************************
    // permission table
    // ****************************************************************
    always_comb begin
        allowed = 1'b0;
        case (chk.ap)
            MFP_AP_SR: begin
                // both bits set is unpredictable; treated as no access
                case ({chk.rom_bit, chk.sys_bit})
                    2'h1:    allowed = chk.priv && !chk.write;
                    2'h2:    allowed = !chk.write;
                    default: allowed = 1'b0;
                endcase
            end
            MFP_AP_PRIV_RW: allowed = chk.priv;
            MFP_AP_USER_RO: allowed = chk.priv || !chk.write;
            default:        allowed = 1'b1;
        endcase
    end

    // no access and reserved fault; client checks; manager passes
    assign chk.dom_fault  = (sel_field == MFP_DOM_NOACC) ||
                            (sel_field == MFP_DOM_RSVD);
    assign chk.perm_fault = (sel_field == MFP_DOM_CLIENT) && !allowed;

endmodule : mfp_dom_check

// *** rtl/mfp_fault_unit.sv ***
// module: mmu fault prioritiser, fault status and fault address capture
//
// Contract
// - record only highest-priority abort source
// - alignment status b0001/b0011, domain meaningless
// - walk abort: L1 b1100, L2 b1110
// - translation: section b0101, page b0111
// - domain fault: section b1001, page b1011
// - permission: section b1101, page b1111
// - external abort b10x0, domain meaningless
// - early fault may leave invalid domain
// - masked aborts reappear on retry
// - no alignment fault on instruction fetch
// - prefetch operation faults update instruction status
// - checked faults latch first aborted address
// - external abort before 1KB: last pre-boundary
// - external abort after 1KB: final word
// - sixteen two-bit domain fields in register
// - domain 00 always domain-faults
// - domain 01 checks permission bits
// - domain 10 behaves as no access
// - domain 11 ignores permission bits
// - AP 00 result from system/ROM bits
// - AP 01/10/11 fixed permission meaning
// - data abort stores status plus domain
// - instruction faults never load address register
`timescale 1ns/1ps
module mfp_fault_unit
    import mfp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // domain access control register port
    input  wire logic        dac_wr,
    input  wire logic [31:0] dac_wdata,
    output logic [31:0]      domain_access_control,
    // control bits
    input  wire logic        sys_bit,
    input  wire logic        rom_bit,
    // access under check
    input  wire logic        acc_valid,
    input  wire logic        acc_ifetch,
    input  wire logic        acc_pf_op,
    input  wire logic        acc_priv,
    input  wire logic        acc_write,
    input  wire logic        acc_page,
    input  wire logic        acc_desc_valid,
    input  wire logic        acc_dom_known,
    input  wire logic [3:0]  acc_domain,
    input  wire logic [1:0]  acc_ap,
    input  wire logic [31:0] modified_virtual_addr,
    input  wire logic        acc_first_word,
    input  wire logic        acc_last_word,
    // raw abort sources
    input  wire logic        align_err,
    input  wire logic        align_half,
    input  wire logic        walk_abort,
    input  wire logic        walk_level2,
    input  wire logic        ext_abort,
    // results to the core
    output logic             abort,
    output logic [7:0]       fault_status_reg,
    output logic [7:0]       ifault_status_reg,
    output logic [31:0]      fault_address_reg
);

    // ****************************************************************
    // domain and permission check
    // ****************************************************************
    mfp_check_if chk_if ();

    assign chk_if.dac     = domain_access_control;
    assign chk_if.domain  = acc_domain;
    assign chk_if.ap      = acc_ap;
    assign chk_if.sys_bit = sys_bit;
    assign chk_if.rom_bit = rom_bit;
    assign chk_if.priv    = acc_priv;
    assign chk_if.write   = acc_write;

    mfp_dom_check u_chk (
        .chk (chk_if.chk)
    );

    // ****************************************************************
    // priority selection
    // ****************************************************************
    mfp_class_t cls;
    logic [3:0] code;
    logic [3:0] dom_rec;

    // ordered if-chain keeps one winner; lower sources are simply dropped
    always_comb begin
        cls = MFP_CLS_NONE;
        if (align_err && !acc_ifetch && !acc_pf_op) begin
            cls = MFP_CLS_ALIGN;
        end else if (walk_abort) begin
            cls = MFP_CLS_XWALK;
        end else if (!acc_desc_valid) begin
            cls = MFP_CLS_XLAT;
        end else if (chk_if.dom_fault) begin
            cls = MFP_CLS_DOM;
        end else if (chk_if.perm_fault) begin
            cls = MFP_CLS_PERM;
        end else if (ext_abort) begin
            cls = MFP_CLS_XABT;
        end
    end

    // status encoding
    always_comb begin
        case (cls)
            MFP_CLS_ALIGN: code = align_half ? MFP_FS_ALIGN_B : MFP_FS_ALIGN_A;
            MFP_CLS_XWALK: code = walk_level2 ? MFP_FS_XWALK_L2 : MFP_FS_XWALK_L1;
            MFP_CLS_XLAT:  code = acc_page ? MFP_FS_XLAT_PAGE : MFP_FS_XLAT_SECT;
            MFP_CLS_DOM:   code = acc_page ? MFP_FS_DOM_PAGE : MFP_FS_DOM_SECT;
            MFP_CLS_PERM:  code = acc_page ? MFP_FS_PERM_PAGE : MFP_FS_PERM_SECT;
            MFP_CLS_XABT:  code = acc_page ? MFP_FS_XABT_PAGE : MFP_FS_XABT_SECT;
            default:       code = 4'h0;
        endcase
    end

    // domain passes through; zeroed for alignment and external aborts, stale cases left as presented
    always_comb begin
        dom_rec = acc_domain;
        if (cls == MFP_CLS_ALIGN || cls == MFP_CLS_XABT) begin
            dom_rec = 4'h0;
        end else if (!acc_dom_known) begin
            dom_rec = acc_domain;
        end
    end

    logic fault_hit;
    logic data_hit;
    logic inst_hit;
    assign fault_hit = acc_valid && (cls != MFP_CLS_NONE);
    assign data_hit  = fault_hit && !acc_ifetch && !acc_pf_op;
    assign inst_hit  = fault_hit && (acc_ifetch || acc_pf_op);

    // transfer state; the status register reads the external abort hold
    logic        data_acc;
    logic        in_burst_r;
    logic        xabt_hold_r;
    logic        far_got_r;
    logic        past_bnd_r;
    logic [31:0] prev_addr_r;
    logic [21:0] start_blk_r;
    logic        crossed;
    assign data_acc = acc_valid && !acc_ifetch && !acc_pf_op;
    assign crossed  = in_burst_r &&
        (modified_virtual_addr[31:MFP_BOUNDARY_LSB] != start_blk_r);

    // ****************************************************************
    // domain access control register
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            domain_access_control <= MFP_DAC_RST;
        end else if (dac_wr) begin
            domain_access_control <= dac_wdata;
        end
    end

    // ****************************************************************
    // abort and status registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            abort <= 1'b0;
        end else begin
            abort <= fault_hit;
        end
    end

    // data status: latched on each data fault outside an external abort hold, held otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_status_reg <= MFP_FSR_RST;
        end else if (data_hit && !(xabt_hold_r && !acc_first_word)) begin
            fault_status_reg <= {dom_rec, code};
        end
    end

    // instruction status, including prefetch operations
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ifault_status_reg <= MFP_FSR_RST;
        end else if (inst_hit) begin
            ifault_status_reg <= {dom_rec, code};
        end
    end

    // ****************************************************************
    // fault address capture for multi-word transfers
    // ****************************************************************
    // external aborts are reported late, so the whole transfer is tracked
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            in_burst_r  <= 1'b0;
            start_blk_r <= 22'h000000;
            prev_addr_r <= 32'h0000_0000;
            past_bnd_r  <= 1'b0;
        end else if (acc_valid && !acc_ifetch && !acc_pf_op) begin
            in_burst_r  <= !acc_last_word;
            prev_addr_r <= modified_virtual_addr;
            if (acc_first_word) begin
                start_blk_r <= modified_virtual_addr[31:MFP_BOUNDARY_LSB];
                past_bnd_r  <= 1'b0;
            end else if (crossed) begin
                past_bnd_r  <= 1'b1;
            end
        end
    end

    // first aborted word claims the address; an external abort comes too
    // late to stop the transfer, so the address follows the later words
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_address_reg <= MFP_FAR_RST;
            xabt_hold_r       <= 1'b0;
            far_got_r         <= 1'b0;
        end else if (data_acc) begin
            if (acc_first_word) begin
                far_got_r <= data_hit;
            end else if (data_hit) begin
                far_got_r <= 1'b1;
            end
            if (xabt_hold_r && !acc_first_word) begin
                // aborted before the boundary: stop at the last pre-boundary word
                if (crossed && !past_bnd_r) begin
                    fault_address_reg <= prev_addr_r;
                    xabt_hold_r       <= 1'b0;
                end else begin
                    fault_address_reg <= modified_virtual_addr;
                    xabt_hold_r       <= !acc_last_word;
                end
            end else if (data_hit && (acc_first_word || !far_got_r)) begin
                fault_address_reg <= modified_virtual_addr;
                xabt_hold_r       <= (cls == MFP_CLS_XABT) && !acc_last_word;
            end else if (acc_first_word) begin
                xabt_hold_r <= 1'b0;
            end
        end
    end

endmodule : mfp_fault_unit

// *** bench/mfp_core_model.sv ***
// core model: takes abort pulses from the fault unit and counts them
`timescale 1ns/1ps
module mfp_core_model (
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   reset,
    // abort from the fault unit
    input  wire logic   abort,
    output logic [15:0] abort_count
);
    // ****************************************************************
    // abort intake
    // ****************************************************************
    // one high cycle is one aborted word, so back-to-back words count twice
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            abort_count <= 16'h0000;
        end else if (abort) begin
            abort_count <= abort_count + 16'h0001;
        end
    end
endmodule : mfp_core_model

// *** bench/mfp_fault_unit_assertions.sv ***
// checker: status codes, priority and register hold of the fault unit
`timescale 1ns/1ps
module mfp_fault_unit_assertions
    import mfp_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // access and sources
    input wire logic        acc_valid,
    input wire logic        acc_ifetch,
    input wire logic        acc_pf_op,
    input wire logic        acc_page,
    input wire logic        acc_desc_valid,
    input wire logic [3:0]  acc_domain,
    input wire logic        acc_first_word,
    input wire logic        acc_last_word,
    input wire logic        align_err,
    input wire logic        align_half,
    input wire logic        walk_abort,
    input wire logic        walk_level2,
    input wire logic        ext_abort,
    // results
    input wire logic        abort,
    input wire logic [7:0]  fault_status_reg,
    input wire logic [31:0] fault_address_reg,
    input wire logic [31:0] domain_access_control
);
    logic [1:0] fld;
    logic       dsw;
    // field of the word's domain; writes never overlap accesses in use
    assign fld = domain_access_control[{acc_domain, 1'b0} +: 2];
    // single-word data access, so no hold from a multi-word transfer
    assign dsw = acc_valid && !acc_ifetch && !acc_pf_op && acc_first_word && acc_last_word;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_walked;
        dsw && !align_err && !walk_abort;
    endsequence
    sequence s_checked;
        s_walked ##0 acc_desc_valid;
    endsequence

    a_align_code: assert property (
        dsw && align_err |=> abort && fault_status_reg[3:0] == ($past(align_half) ? 4'h3 : 4'h1))
        else $error("alignment status wrong");
    a_walk_code: assert property (
        dsw && !align_err && walk_abort |=> abort && fault_status_reg[3:0] == ($past(walk_level2) ? 4'hE : 4'hC))
        else $error("walk abort status wrong");
    a_xlat_code: assert property (
        s_walked ##0 !acc_desc_valid |=> abort && fault_status_reg[3:0] == ($past(acc_page) ? 4'h7 : 4'h5))
        else $error("translation status wrong");
    a_dom_code: assert property (
        s_checked ##0 !fld[0] |=> fault_status_reg == {$past(acc_domain), ($past(acc_page) ? 4'hB : 4'h9)})
        else $error("domain fault status wrong");
    a_xabt_code: assert property (
        s_checked ##0 fld == 2'h3 && ext_abort |=> abort && fault_status_reg[3:0] == ($past(acc_page) ? 4'hA : 4'h8))
        else $error("external abort status wrong");
    a_clean_hold: assert property (
        s_checked ##0 fld == 2'h3 && !ext_abort |=> !abort && $stable(fault_status_reg) && $stable(fault_address_reg))
        else $error("clean access changed state");
    a_ifetch_noalign: assert property (
        acc_valid && acc_ifetch && align_err && !walk_abort && acc_desc_valid && !ext_abort && fld == 2'h3
        |=> !abort)
        else $error("alignment fault on fetch");
    a_instr_hold: assert property (
        acc_valid && (acc_ifetch || acc_pf_op) |=> $stable(fault_address_reg) && $stable(fault_status_reg))
        else $error("fetch fault touched data registers");
    a_idle_quiet: assert property (
        !acc_valid |=> !abort)
        else $error("abort without an access");
endmodule : mfp_fault_unit_assertions

bind mfp_fault_unit mfp_fault_unit_assertions u_assert (
    .ref_clk, .reset, .acc_valid, .acc_ifetch, .acc_pf_op, .acc_page, .acc_desc_valid, .acc_domain,
    .acc_first_word, .acc_last_word, .align_err, .align_half, .walk_abort, .walk_level2, .ext_abort,
    .abort, .fault_status_reg, .fault_address_reg, .domain_access_control
);

// *** bench/test_mfp_fault_unit.sv ***
// testbench: fault priority, domain, permission and fault address cases
`timescale 1ns/1ps
module test_mfp_fault_unit
    import mfp_pkg::*;
;
    logic        ref_clk, reset, dac_wr, sys_bit, rom_bit, acc_valid, acc_ifetch, acc_pf_op, acc_priv;
    logic        acc_write, acc_page, acc_desc_valid, acc_dom_known, acc_first_word, acc_last_word;
    logic        align_err, align_half, walk_abort, walk_level2, ext_abort, abort;
    logic [31:0] dac_wdata, domain_access_control, modified_virtual_addr, fault_address_reg, keep_a;
    logic [7:0]  fault_status_reg, ifault_status_reg, keep_s;
    logic [3:0]  acc_domain;
    logic [1:0]  acc_ap;
    logic [15:0] core_aborts;
    int          failures = 0, compares = 0, cycles = 0, exp_ab = 0;

    mfp_fault_unit DUT (.ref_clk, .reset, .dac_wr, .dac_wdata, .domain_access_control, .sys_bit, .rom_bit,
        .acc_valid, .acc_ifetch, .acc_pf_op, .acc_priv, .acc_write, .acc_page, .acc_desc_valid, .acc_dom_known,
        .acc_domain, .acc_ap, .modified_virtual_addr, .acc_first_word, .acc_last_word, .align_err, .align_half,
        .walk_abort, .walk_level2, .ext_abort, .abort, .fault_status_reg, .ifault_status_reg, .fault_address_reg);
    mfp_core_model u_core (.ref_clk, .reset, .abort, .abort_count(core_aborts));

    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // the run needs some 210 cycles; the ceiling leaves a wide margin
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // quiet access: privileged read, valid descriptor, no raw source
    task automatic idle();
        {acc_ifetch, acc_pf_op, acc_write, acc_page, align_err, align_half, walk_abort} = '0;
        {walk_level2, ext_abort, sys_bit, rom_bit} = '0;
        {acc_priv, acc_desc_valid, acc_dom_known, acc_first_word, acc_last_word} = '1;
        acc_domain = 4'h0;
        acc_ap = 2'h3;
        modified_virtual_addr = 32'h0000_0100;
    endtask : idle
    task automatic set_dac(input logic [31:0] v);
        dac_wdata = v;
        dac_wr = 1'b1;
        @(negedge ref_clk);
        dac_wr = 1'b0;
        check(domain_access_control, v);
    endtask : set_dac
    // one single-word access; result is registered, seen at the next low phase
    task automatic one(input logic ea, input logic [7:0] es, input logic [7:0] m);
        keep_s = fault_status_reg;
        acc_valid = 1'b1;
        @(negedge ref_clk);
        acc_valid = 1'b0;
        exp_ab += ea;
        check({31'h0, abort}, {31'h0, ea});
        check(fault_status_reg & m, (ea ? es : keep_s) & m);
        @(negedge ref_clk);  // quiet cycle: valid never drops and rises in one step
    endtask : one
    // four words across the 1KB boundary at 0x400, held valid back to back
    task automatic xfer(input logic [3:0] bad, input logic [3:0] xab, input logic [31:0] far_exp);
        for (int k = 0; k < 4; k++) begin
            modified_virtual_addr = 32'h0000_03F8 + 32'(4 * k);
            acc_first_word = (k == 0);
            acc_last_word = (k == 3);
            acc_desc_valid = !bad[k];
            ext_abort = xab[k];
            acc_valid = 1'b1;
            @(negedge ref_clk);
        end
        acc_valid = 1'b0;
        exp_ab += $countones(bad | xab);
        check(fault_address_reg, far_exp);
        idle();
        @(negedge ref_clk);
    endtask : xfer

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_domains();
        idle();
        set_dac(32'hE4E4_E4E4);
        acc_ap = 2'h0;
        for (int d = 0; d < 16; d++) begin
            acc_domain = d[3:0];
            acc_page = d[2];
            if (d[1:0] == 2'h3) one(1'b0, 8'h00, 8'hFF);
            else if (d[1:0] == 2'h1) one(1'b1, {d[3:0], (d[2] ? 4'hF : 4'hD)}, 8'hFF);
            else one(1'b1, {d[3:0], (d[2] ? 4'hB : 4'h9)}, 8'hFF);
        end
        $display("test domains done");
    endtask : t_domains
    task automatic t_perm();
        logic ok;
        idle();
        set_dac(32'h5555_5555);
        for (int i = 0; i < 64; i++) begin
            {acc_write, acc_priv, rom_bit, sys_bit, acc_ap} = i[5:0];
            case (acc_ap)
                2'h0: ok = (sys_bit ^ rom_bit) && !acc_write && (acc_priv || rom_bit);
                2'h1: ok = acc_priv;
                2'h2: ok = acc_priv || !acc_write;
                default: ok = 1'b1;
            endcase
            one(!ok, 8'h0D, 8'hFF);
        end
        $display("test permissions done");
    endtask : t_perm
    // every source at once, then each removed in turn and the word retried
    task automatic t_prio();
        idle();
        set_dac(32'h0000_0000);
        {align_err, align_half, walk_abort, walk_level2, ext_abort, acc_page} = 6'h3F;
        acc_desc_valid = 1'b0;
        acc_domain = 4'h5;
        modified_virtual_addr = 32'h0000_1234;
        one(1'b1, 8'h03, 8'h0F);
        check(fault_address_reg, 32'h0000_1234);
        align_half = 1'b0;
        one(1'b1, 8'h01, 8'h0F);
        align_err = 1'b0;
        one(1'b1, 8'h5E, 8'hFF);
        walk_level2 = 1'b0;
        one(1'b1, 8'h0C, 8'h0F);
        walk_abort = 1'b0;
        one(1'b1, 8'h57, 8'hFF);
        acc_desc_valid = 1'b1;
        one(1'b1, 8'h5B, 8'hFF);
        set_dac(32'h0000_0400);
        acc_ap = 2'h0;
        one(1'b1, 8'h5F, 8'hFF);
        set_dac(32'h0000_0C00);
        one(1'b1, 8'h0A, 8'h0F);
        acc_page = 1'b0;
        one(1'b1, 8'h08, 8'h0F);
        ext_abort = 1'b0;
        modified_virtual_addr = 32'h0000_2000;
        keep_a = fault_address_reg;
        one(1'b0, 8'h00, 8'hFF);
        check(fault_address_reg, keep_a);
        $display("test priority done");
    endtask : t_prio
    task automatic t_instr();
        idle();
        acc_domain = 4'h5;
        {acc_ifetch, align_err} = 2'h3;
        keep_a = fault_address_reg;
        one(1'b0, fault_status_reg, 8'hFF);
        {align_err, acc_desc_valid, acc_page} = 3'h5;
        one(1'b1, fault_status_reg, 8'hFF);
        check(ifault_status_reg, 8'h57);
        {acc_ifetch, acc_pf_op, acc_page} = 3'h2;
        one(1'b1, fault_status_reg, 8'hFF);
        check(ifault_status_reg[3:0], 4'h5);
        check(fault_address_reg, keep_a);
        $display("test instruction side done");
    endtask : t_instr
    task automatic t_multi();
        idle();
        xfer(4'b0110, 4'b0000, 32'h0000_03FC);
        xfer(4'b0000, 4'b0001, 32'h0000_03FC);
        xfer(4'b0000, 4'b0100, 32'h0000_0404);
        $display("test multi-word done");
    endtask : t_multi

    initial begin
        reset = 1'b1;
        dac_wdata = 32'h0000_0000;
        {acc_valid, dac_wr} = 2'h0;
        idle();
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        check({abort, ifault_status_reg, fault_status_reg}, {1'b0, MFP_FSR_RST, MFP_FSR_RST});
        check(fault_address_reg, MFP_FAR_RST);
        check(domain_access_control, MFP_DAC_RST);
        t_domains();
        t_perm();
        t_prio();
        t_instr();
        set_dac(32'h0000_0003);
        t_multi();
        check(core_aborts, exp_ab[15:0]);
        final_report();
    end
endmodule : test_mfp_fault_unit
